// *** mifc_pkg.sv ***
// package: constants, field layout and carrier types of the interrupt flag controller
`default_nettype none
package mifc_pkg;
   // =========================================================
   // register byte offsets on the wishbone bus
   localparam logic [7:0] OFF_CTL3 = 8'h00;
   localparam logic [7:0] OFF_G02 = 8'h04;
   localparam logic [7:0] OFF_G1 = 8'h08;
   localparam logic [7:0] OFF_MISC = 8'h0C;
   localparam logic [7:0] OFF_G3 = 8'h10;
   localparam logic [7:0] OFF_GCTL = 8'h14;
   localparam logic [7:0] OFF_STAT = 8'h18;
   // =========================================================
   // field layout of control register three
   localparam int G4_IDX = 0;
   localparam int T0_IDX = 1;
   localparam int T1_IDX = 2;
   localparam int G5_IDX = 3;
   localparam int FLAG_LSB = 4;
   localparam int NSRC = 4;
   localparam int SRC_W = 2;
   localparam int GIE_BIT = 0;
   localparam int NGRP = 4;
   // group register index in the group array
   localparam int GR_G02 = 0;
   localparam int GR_G1 = 1;
   localparam int GR_MISC = 2;
   localparam int GR_G3 = 3;
   // =========================================================
   // implemented bits of each group register
   localparam logic [7:0] IMPL_FULL = 8'hFF;
   localparam logic [7:0] IMPL_NO_T2 = 8'h33;
   localparam logic [7:0] IMPL_T1 = 8'h77;
   localparam logic [7:0] IMPL_T1_NO_B = 8'h33;
   localparam logic [7:0] IMPL_T3 = 8'h33;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   // which group feeds group5 (1) or group4 (0)
   localparam logic [NGRP-1:0] GRP_TO_G5 = 4'hC;
   // =========================================================
   // program counter width and default vector and priority tables
   localparam int PC_W = 13;
   localparam logic [4*PC_W-1:0] VEC_DEFAULT = {13'h001C, 13'h0018, 13'h0014, 13'h0010};
   // highest priority in the low slot
   localparam logic [NSRC*SRC_W-1:0] PRIO_DEFAULT = {2'h3, 2'h2, 2'h1, 2'h0};
   // =========================================================
   // service state
   typedef enum logic {ST_RUN, ST_IN_ISR} mifc_state_e;
   // peripheral event pulses, nibbles ordered as the flag bits 7..4
   typedef struct packed {
      logic tick1;
      logic tick0;
      logic [3:0] grp02;
      logic [3:0] grp1;
      logic [3:0] misc;
      logic [3:0] grp3;
   } mifc_evt_s;
   // requests to the processor core and its return stack
   typedef struct packed {
      logic push;
      logic [PC_W-1:0] push_pc;
      logic pop;
      logic load;
      logic [PC_W-1:0] load_pc;
   } mifc_jump_s;
endpackage
`default_nettype wire

// *** mifc_prio_pick.sv ***
// fixed-priority pick of one pending vector source
`default_nettype none
module mifc_prio_pick #(
   parameter int N = 4,
   parameter int IW = 2,
   parameter logic [N*IW-1:0] PRIO_TBL = {2'h3, 2'h2, 2'h1, 2'h0}
) (
   input wire logic [N-1:0] pend_i,
   output logic valid_o,
   output logic [IW-1:0] idx_o
);
   // =========================================================
   // elaboration check
   if ((1 << IW) < N) begin : g_bad
      $error("mifc_prio_pick: index width too small");
   end
   // =========================================================
   // scan from lowest to highest priority, last hit wins
   always_comb begin
      valid_o = 1'b0;
      idx_o = '0;
      for (int k = N - 1; k >= 0; k--) begin
         if (pend_i[PRIO_TBL[k*IW +: IW]]) begin
            valid_o = 1'b1;
            idx_o = PRIO_TBL[k*IW +: IW];
         end
      end
   end
endmodule
`default_nettype wire

// *** mifc_top.sv ***
// interrupt flag controller: flags, enables, grouping, priority and vector entry
//
// Local design decisions: the address map and the Wishbone register port.
`default_nettype none
module mifc_top #(
   parameter int ADDR_W = 8,
   parameter bit HAS_TMR2 = 1'b1,
   parameter bit HAS_TMR1B = 1'b1,
   parameter bit HAS_TMR3 = 1'b1,
   parameter logic [4*mifc_pkg::PC_W-1:0] VEC_TBL = mifc_pkg::VEC_DEFAULT,
   parameter logic [mifc_pkg::NSRC*mifc_pkg::SRC_W-1:0] PRIO_TBL = mifc_pkg::PRIO_DEFAULT
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire mifc_pkg::mifc_evt_s evt_i,
   input wire logic boundary_i,
   input wire logic [mifc_pkg::PC_W-1:0] pc_next_i,
   input wire logic stack_full_i,
   input wire logic return_from_irq_instr_i,
   input wire logic [mifc_pkg::PC_W-1:0] pop_pc_i,
   input wire logic sleep_i,
   output mifc_pkg::mifc_jump_s jump_o,
   output logic wake_o
);
   // =========================================================
   // elaboration check
   if (ADDR_W < 5 || ADDR_W > 32) begin : g_bad
      $error("mifc_top: address width must be 5 to 32");
   end

   localparam logic [7:0] IMPL [mifc_pkg::NGRP] = '{
      HAS_TMR2 ? mifc_pkg::IMPL_FULL : mifc_pkg::IMPL_NO_T2,
      HAS_TMR1B ? mifc_pkg::IMPL_T1 : mifc_pkg::IMPL_T1_NO_B,
      mifc_pkg::IMPL_FULL,
      HAS_TMR3 ? mifc_pkg::IMPL_T3 : mifc_pkg::RST_BYTE};

   // word address match, used for every register
   function automatic logic reg_hit(input logic [ADDR_W-1:0] adr, input logic [7:0] off);
      logic [31:0] full;
      full = 32'(adr);
      return full[31:2] == 30'(off[7:2]);
   endfunction

   // =========================================================
   // declarations
   logic ack_r;
   logic [31:0] rdat_r;
   logic [7:0] ctl3_r;
   logic [7:0] ctl3_nxt;
   logic [7:0] grp_r [mifc_pkg::NGRP];
   logic [7:0] grp_nxt [mifc_pkg::NGRP];
   logic [3:0] act_q [mifc_pkg::NGRP];
   logic gie_r;
   logic wake_r;
   mifc_pkg::mifc_state_e st_r;
   mifc_pkg::mifc_jump_s jump_r;
   logic [mifc_pkg::SRC_W-1:0] last_idx_r;
   logic req_go;
   logic wr_go;
   logic [7:0] wbyte;
   logic [3:0] evt_nib [mifc_pkg::NGRP];
   logic [mifc_pkg::NGRP-1:0] grp_rise;
   logic g4_set;
   logic g5_set;
   logic [mifc_pkg::NSRC-1:0] pend;
   logic pick_valid;
   logic [mifc_pkg::SRC_W-1:0] pick_idx;
   logic take;
   logic flag_rise;

   // bus request strobes, data in byte lane zero
   assign req_go = wb_cyc_i && wb_stb_i && !ack_r;
   assign wr_go = req_go && wb_we_i && wb_sel_i[0];
   assign wbyte = wb_dat_i[7:0];
   assign evt_nib[mifc_pkg::GR_G02] = evt_i.grp02;
   assign evt_nib[mifc_pkg::GR_G1] = evt_i.grp1;
   assign evt_nib[mifc_pkg::GR_MISC] = evt_i.misc;
   assign evt_nib[mifc_pkg::GR_G3] = evt_i.grp3;

   // =========================================================
   // group registers: source flags and enables
   always_comb begin
      for (int i = 0; i < mifc_pkg::NGRP; i++) begin
         grp_nxt[i] = grp_r[i];
         if (wr_go && reg_hit(wb_adr_i, mifc_pkg::OFF_G02 + 8'(4 * i))) begin
            grp_nxt[i] = wbyte;
         end
         // event set wins over a software clear
         grp_nxt[i][7:4] = grp_nxt[i][7:4] | evt_nib[i];
         grp_nxt[i] = grp_nxt[i] & IMPL[i];
      end
   end

   for (genvar g = 0; g < mifc_pkg::NGRP; g++) begin : g_grp
      // flag register and gated activity history
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            grp_r[g] <= mifc_pkg::RST_BYTE;
            act_q[g] <= 4'h0;
         end else if (ce_i) begin
            grp_r[g] <= grp_nxt[g];
            act_q[g] <= grp_r[g][7:4] & grp_r[g][3:0];
         end
      end
      // enabled source flag newly set
      assign grp_rise[g] = |(grp_r[g][7:4] & grp_r[g][3:0] & ~act_q[g]);
   end

   // group flags collect their sources
   always_comb begin
      g4_set = 1'b0;
      g5_set = 1'b0;
      for (int i = 0; i < mifc_pkg::NGRP; i++) begin
         if (mifc_pkg::GRP_TO_G5[i]) begin
            g5_set = g5_set | grp_rise[i];
         end else begin
            g4_set = g4_set | grp_rise[i];
         end
      end
   end

   // =========================================================
   // vector request selection
   assign pend = ctl3_r[7:4] & ctl3_r[3:0];
   assign take = ce_i && boundary_i && gie_r && !stack_full_i && !return_from_irq_instr_i && pick_valid;

   mifc_prio_pick #(
      .N(mifc_pkg::NSRC),
      .IW(mifc_pkg::SRC_W),
      .PRIO_TBL(PRIO_TBL)
   ) u_pick (
      .pend_i(pend),
      .valid_o(pick_valid),
      .idx_o(pick_idx)
   );

   // =========================================================
   // control register three
   always_comb begin
      ctl3_nxt = ctl3_r;
      if (wr_go && reg_hit(wb_adr_i, mifc_pkg::OFF_CTL3)) begin
         ctl3_nxt = wbyte;
      end
      if (take) begin
         ctl3_nxt[mifc_pkg::FLAG_LSB + 32'(pick_idx)] = 1'b0;
      end
      // sets come last so they win
      ctl3_nxt[mifc_pkg::FLAG_LSB + mifc_pkg::T0_IDX] |= evt_i.tick0;
      ctl3_nxt[mifc_pkg::FLAG_LSB + mifc_pkg::T1_IDX] |= evt_i.tick1;
      ctl3_nxt[mifc_pkg::FLAG_LSB + mifc_pkg::G4_IDX] |= g4_set;
      ctl3_nxt[mifc_pkg::FLAG_LSB + mifc_pkg::G5_IDX] |= g5_set;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctl3_r <= mifc_pkg::RST_BYTE;
      end else if (ce_i) begin
         ctl3_r <= ctl3_nxt;
      end
   end

   // =========================================================
   // global enable: software sets, entry clears
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gie_r <= 1'b0;
      end else if (ce_i) begin
         if (take) begin
            gie_r <= 1'b0;
         end else if (wr_go && reg_hit(wb_adr_i, mifc_pkg::OFF_GCTL)) begin
            gie_r <= wbyte[mifc_pkg::GIE_BIT];
         end
      end
   end

   // =========================================================
   // service state and last vector taken
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r <= mifc_pkg::ST_RUN;
         last_idx_r <= '0;
      end else if (ce_i) begin
         case (st_r)
            mifc_pkg::ST_RUN: begin
               if (take) begin
                  st_r <= mifc_pkg::ST_IN_ISR;
               end
            end
            mifc_pkg::ST_IN_ISR: begin
               if (return_from_irq_instr_i) begin
                  st_r <= mifc_pkg::ST_RUN;
               end
            end
            default: begin
               st_r <= mifc_pkg::ST_RUN;
            end
         endcase
         if (take) begin
            last_idx_r <= pick_idx;
         end
      end
   end

   // =========================================================
   // core and stack requests
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         jump_r <= '0;
      end else if (ce_i) begin
         jump_r.push <= take;
         jump_r.pop <= return_from_irq_instr_i;
         jump_r.load <= take || return_from_irq_instr_i;
         if (take) begin
            jump_r.push_pc <= pc_next_i;
            jump_r.load_pc <= VEC_TBL[32'(pick_idx) * mifc_pkg::PC_W +: mifc_pkg::PC_W];
         end else if (return_from_irq_instr_i) begin
            jump_r.load_pc <= pop_pc_i;
         end
      end
   end

   // =========================================================
   // wake on any flag newly set while asleep
   always_comb begin
      flag_rise = |(ctl3_nxt[7:4] & ~ctl3_r[7:4]);
      for (int i = 0; i < mifc_pkg::NGRP; i++) begin
         flag_rise = flag_rise | (|(grp_nxt[i][7:4] & ~grp_r[i][7:4]));
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wake_r <= 1'b0;
      end else if (ce_i) begin
         wake_r <= sleep_i && flag_rise;
      end
   end

   // =========================================================
   // wishbone answer and read data
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
         rdat_r <= mifc_pkg::RST_WORD;
      end else if (ce_i) begin
         ack_r <= req_go;
         rdat_r <= mifc_pkg::RST_WORD;
         if (req_go && !wb_we_i) begin
            if (reg_hit(wb_adr_i, mifc_pkg::OFF_CTL3)) begin
               rdat_r[7:0] <= ctl3_r;
            end
            for (int i = 0; i < mifc_pkg::NGRP; i++) begin
               if (reg_hit(wb_adr_i, mifc_pkg::OFF_G02 + 8'(4 * i))) begin
                  rdat_r[7:0] <= grp_r[i];
               end
            end
            if (reg_hit(wb_adr_i, mifc_pkg::OFF_GCTL)) begin
               rdat_r[mifc_pkg::GIE_BIT] <= gie_r;
            end
            if (reg_hit(wb_adr_i, mifc_pkg::OFF_STAT)) begin
               rdat_r[7:0] <= {last_idx_r, 1'b0, st_r == mifc_pkg::ST_IN_ISR, pend};
            end
         end
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = rdat_r;
   assign jump_o = jump_r;
   assign wake_o = wake_r;

   // =========================================================
   // assertions
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_tick_flag_set: assert property (ce_i && evt_i.tick0 |=> ctl3_r[mifc_pkg::FLAG_LSB + mifc_pkg::T0_IDX])
      else $error("tick0 event did not set its flag");
   a_blocked_hold: assert property (ce_i && !gie_r && evt_i.grp1[1] && IMPL[1][5] |=> grp_r[1][5])
      else $error("blocked request not recorded");
   a_no_jump_disabled: assert property (ce_i && pend == 4'h0 |=> !jump_o.push)
      else $error("jump without enabled request");
   a_no_jump_gie: assert property (ce_i && !gie_r |=> !jump_o.push)
      else $error("jump while global enable is zero");
   a_stack_full_block: assert property (ce_i && stack_full_i |=> !jump_o.push)
      else $error("jump while stack is full");
   a_entry_push_load: assert property (take |=> jump_o.push && jump_o.load
      && jump_o.push_pc == $past(pc_next_i) && !gie_r)
      else $error("entry did not push pc and load vector");
   a_entry_gie_clear: assert property (take |=> !gie_r)
      else $error("global enable not cleared on entry");
   a_return_from_irq_instr_pop: assert property (ce_i && return_from_irq_instr_i |=> jump_o.pop && jump_o.load
      && jump_o.load_pc == $past(pop_pc_i))
      else $error("return did not pop saved pc");
   a_group_set: assert property (ce_i && g4_set |=> ctl3_r[mifc_pkg::FLAG_LSB + mifc_pkg::G4_IDX])
      else $error("group4 flag not set by source");
   a_group_clear: assert property (take && pick_idx == 2'(mifc_pkg::G5_IDX) && !g5_set && !wr_go
      && evt_i.misc == 4'h0
      |=> !ctl3_r[mifc_pkg::FLAG_LSB + mifc_pkg::G5_IDX] && $stable(grp_r[mifc_pkg::GR_MISC][7:4]))
      else $error("group5 service clears wrong flags");
   a_wake_new: assert property (ce_i && sleep_i && flag_rise |=> wake_o)
      else $error("new flag did not wake");
   a_no_wake_old: assert property (ce_i && !flag_rise |=> !wake_o)
      else $error("wake without a new flag");
   a_timer3_unimpl: assert property ((grp_r[mifc_pkg::GR_G3] & ~mifc_pkg::IMPL_T3) == 8'h00)
      else $error("timer3 unimplemented bits set");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o || !ce_i)
      else $error("ack held longer than one cycle");

   c_entry: cover property (take);
   c_return: cover property (jump_o.pop);
   c_wake: cover property (wake_o);
   c_nested: cover property (take ##[1:20] take);
endmodule
`default_nettype wire

// *** mifc_core_model.sv ***
// model of the processor core and its return stack
`default_nettype none
module mifc_core_model #(
   parameter int DEPTH = 4
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire mifc_pkg::mifc_jump_s jump_i,
   input wire logic fill_i,
   output logic [mifc_pkg::PC_W-1:0] pc_next_o,
   output logic [mifc_pkg::PC_W-1:0] pop_pc_o,
   output logic stack_full_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [mifc_pkg::PC_W-1:0] pc_r;
   logic [mifc_pkg::PC_W-1:0] stk_r [DEPTH];
   int sp_r;
   // =========================================================
   // program counter: steps each cycle, jumps on load
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pc_r <= 13'h0100;
      end else if (jump_i.load) begin
         pc_r <= jump_i.load_pc;
      end else begin
         pc_r <= pc_r + 13'h0001;
      end
   end
   assign pc_next_o = pc_r + 13'h0001;
   // return stack: push on entry, pop on return
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sp_r <= 0;
      end else if (jump_i.push && sp_r < DEPTH) begin
         stk_r[sp_r] <= jump_i.push_pc;
         sp_r <= sp_r + 1;
      end else if (jump_i.pop && sp_r > 0) begin
         sp_r <= sp_r - 1;
      end
   end
   // empty stack shows a value unlike any saved one
   assign pop_pc_o = (sp_r > 0) ? stk_r[sp_r-1] : ~pc_r;
   assign stack_full_o = fill_i || (sp_r == DEPTH);
endmodule
`default_nettype wire

// *** test_mifc_top.sv ***
// self-checking bench of the interrupt flag controller
`default_nettype none
module test_mifc_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] C3 = mifc_pkg::OFF_CTL3;
   localparam logic [7:0] G02 = mifc_pkg::OFF_G02;
   localparam logic [7:0] G1 = mifc_pkg::OFF_G1;
   localparam logic [7:0] MS = mifc_pkg::OFF_MISC;
   localparam logic [7:0] G3 = mifc_pkg::OFF_G3;
   localparam logic [7:0] GC = mifc_pkg::OFF_GCTL;
   localparam logic [7:0] SR = mifc_pkg::OFF_STAT;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic ce = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] dat = 32'h0000_0000;
   logic [3:0] sel = 4'hF;
   logic [31:0] wb_dat_o;
   logic [31:0] q;
   logic wb_ack_o;
   mifc_pkg::mifc_evt_s evt = '0;
   mifc_pkg::mifc_jump_s jump;
   logic return_from_irq_instr = 1'b0;
   logic sleep = 1'b0;
   logic fill = 1'b0;
   logic wake;
   logic full;
   logic [mifc_pkg::PC_W-1:0] pcn, popv, pcn_q, pop_q, last_ld;
   int errors = 0;
   int cmp_count = 0;
   int pushes = 0;
   int pops = 0;
   int wakes = 0;
   int cycles = 0;
   always #25 clk_i = ~clk_i;
   // =========================================================
   // design and core model
   mifc_top dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .evt_i(evt), .boundary_i(1'b1), .pc_next_i(pcn),
      .stack_full_i(full), .return_from_irq_instr_i(return_from_irq_instr), .pop_pc_i(popv), .sleep_i(sleep),
      .jump_o(jump), .wake_o(wake));
   mifc_core_model core (.clk_i(clk_i), .rst_i(rst_i), .jump_i(jump), .fill_i(fill),
      .pc_next_o(pcn), .pop_pc_o(popv), .stack_full_o(full));
   // =========================================================
   // shared tasks
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         $display("BAD %s exp %h got %h", n, e, g);
         errors++;
      end
   endtask
   // classic single cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= 32'(d);
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1) @(posedge clk_i);
      q = wb_dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      wb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      wb(1'b0, a, 8'h00);
      chk($sformatf("reg %h", a), 32'(e), q);
   endtask
   task automatic pulse(input logic [17:0] v);
      @(posedge clk_i);
      evt <= mifc_pkg::mifc_evt_s'(v);
      @(posedge clk_i);
      evt <= '0;
      repeat (4) @(posedge clk_i);
   endtask
   task automatic ret();
      @(posedge clk_i);
      return_from_irq_instr <= 1'b1;
      @(posedge clk_i);
      return_from_irq_instr <= 1'b0;
      repeat (3) @(posedge clk_i);
   endtask
   // watch core requests, wake pulses and the run length
   always @(posedge clk_i) begin
      pcn_q <= pcn;
      pop_q <= popv;
      cycles++;
      if (jump.push === 1'b1) begin
         pushes++;
         last_ld = jump.load_pc;
         chk("push_pc", 32'(pcn_q), 32'(jump.push_pc));
         chk("load", 32'h1, 32'(jump.load));
      end
      if (jump.pop === 1'b1) begin
         pops++;
         chk("pop_pc", 32'(pop_q), 32'(jump.load_pc));
      end
      if (wake === 1'b1) wakes++;
      if (cycles == 5000) begin
         errors++;
         tally_and_finish();
      end
   end
   // =========================================================
   // scenarios
   task automatic t_reset();
      rd(C3, 8'h00);
      rd(G02, 8'h00);
      rd(G1, 8'h00);
      rd(MS, 8'h00);
      rd(G3, 8'h00);
      rd(GC, 8'h00);
      $display("done reset values");
   endtask
   task automatic t_masks();
      wr(G02, 8'hFF);
      rd(G02, 8'hFF);
      wr(G1, 8'hFF);
      rd(G1, 8'h77);
      wr(MS, 8'hFF);
      rd(MS, 8'hFF);
      wr(G3, 8'hFF);
      rd(G3, 8'h33);
      wr(G02, 8'h00);
      wr(G1, 8'h00);
      wr(MS, 8'h00);
      wr(G3, 8'h00);
      wr(C3, 8'hFF);
      rd(C3, 8'hFF);
      wr(C3, 8'h00);
      rd(C3, 8'h00);
      wr(8'h1C, 8'h5A);
      rd(8'h1C, 8'h00);
      $display("done field layout");
   endtask
   task automatic t_gate();
      int p0;
      p0 = pushes;
      wr(GC, 8'h01);
      pulse(18'h1_0000);
      rd(C3, 8'h20);
      chk("pushes", 32'(p0), 32'(pushes));
      wr(C3, 8'h00);
      rd(C3, 8'h00);
      $display("done enable gate");
   endtask
   task automatic t_entry();
      int p0;
      int r0;
      p0 = pushes;
      r0 = pops;
      wr(GC, 8'h00);
      wr(C3, 8'h02);
      pulse(18'h1_0000);
      rd(C3, 8'h22);
      chk("pushes", 32'(p0), 32'(pushes));
      wr(GC, 8'h01);
      repeat (4) @(posedge clk_i);
      chk("pushes", 32'(p0 + 1), 32'(pushes));
      chk("vector", 32'h14, 32'(last_ld));
      rd(GC, 8'h00);
      rd(C3, 8'h02);
      ret();
      chk("pops", 32'(r0 + 1), 32'(pops));
      $display("done entry and return");
   endtask
   task automatic t_prio();
      wr(C3, 8'h06);
      pulse(18'h3_0000);
      wr(GC, 8'h01);
      repeat (4) @(posedge clk_i);
      chk("vector", 32'h14, 32'(last_ld));
      rd(C3, 8'h46);
      rd(SR, 8'h54);
      wr(GC, 8'h01);
      repeat (4) @(posedge clk_i);
      chk("vector", 32'h18, 32'(last_ld));
      ret();
      ret();
      wr(C3, 8'h00);
      $display("done priority");
   endtask
   task automatic t_full();
      int p0;
      p0 = pushes;
      @(posedge clk_i);
      fill <= 1'b1;
      wr(C3, 8'h02);
      pulse(18'h1_0000);
      wr(GC, 8'h01);
      repeat (6) @(posedge clk_i);
      chk("pushes", 32'(p0), 32'(pushes));
      fill <= 1'b0;
      repeat (4) @(posedge clk_i);
      chk("pushes", 32'(p0 + 1), 32'(pushes));
      ret();
      wr(C3, 8'h00);
      $display("done stack full");
   endtask
   task automatic t_group();
      wr(G02, 8'h02);
      wr(C3, 8'h01);
      pulse(18'h0_2000);
      rd(G02, 8'h22);
      rd(C3, 8'h11);
      wr(GC, 8'h01);
      repeat (4) @(posedge clk_i);
      chk("vector", 32'h10, 32'(last_ld));
      rd(C3, 8'h01);
      rd(G02, 8'h22);
      ret();
      wr(G02, 8'h00);
      pulse(18'h0_1000);
      rd(G02, 8'h10);
      rd(C3, 8'h01);
      wr(MS, 8'h08);
      pulse(18'h0_0080);
      rd(C3, 8'h81);
      wr(C3, 8'h88);
      wr(GC, 8'h01);
      repeat (4) @(posedge clk_i);
      chk("vector", 32'h1C, 32'(last_ld));
      rd(C3, 8'h08);
      rd(MS, 8'h88);
      ret();
      pulse(18'h0_0200);
      rd(G1, 8'h20);
      wr(G1, 8'h00);
      wr(MS, 8'h00);
      wr(G02, 8'h00);
      wr(C3, 8'h00);
      $display("done group flags");
   endtask
   task automatic t_wake();
      int w0;
      w0 = wakes;
      @(posedge clk_i);
      sleep <= 1'b1;
      pulse(18'h2_0000);
      chk("wakes", 32'(w0 + 1), 32'(wakes));
      pulse(18'h2_0000);
      chk("wakes", 32'(w0 + 1), 32'(wakes));
      sleep <= 1'b0;
      wr(C3, 8'h00);
      $display("done wake");
   endtask
   // events are ignored while the clock enable is low
   task automatic t_freeze();
      @(posedge clk_i);
      ce <= 1'b0;
      pulse(18'h2_0000);
      ce <= 1'b1;
      rd(C3, 8'h00);
      $display("done clock enable");
   endtask
   // main sequence
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_masks();
      t_gate();
      t_entry();
      t_prio();
      t_full();
      t_group();
      t_wake();
      t_freeze();
      tally_and_finish();
   end
endmodule
`default_nettype wire
